// file: rtl/ulsf_top.v
// Purpose: line status flags of one uart channel, read over apb
// Assumes: rx/tx datapath events and occupancy arrive as asynchronous pins
// Notes:   rx fifo error tags are mirrored per slot, indexed by fifo position
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ulsf_defs.vh"
// Overview of operation
// - any of bits 1..4 raises the line status interrupt when it is enabled
// - in single holding register mode bit 7 reads zero
// - in fifo mode bit 7 is set while any stored character has an error tag
// - bit 6 high when holding and shift registers are both empty; resets high
// - bit 6 low while holding register or shift register holds a word
// - reading the line status register clears the receive error bits 1..4; bit 7 follows the fifo
module ulsf_top #(
  parameter DEPTH = `ULSF_FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        RX_PUSH,
  input  wire        RX_POP,
  input  wire [2:0]  RX_TAG_IN,
  input  wire        RX_OVERRUN,
  input  wire        RX_DATA_READY,
  input  wire        TX_HOLD_EMPTY,
  input  wire        TX_SHIFT_EMPTY,
  output reg         RLS_IRQ
);
  // synchronised pin inputs; the tx empty pins idle high, so their stages
  // reset high too, else bit 6 would dip for two cycles after reset
  wire [8:0] s;
  ulsf_sync #(.W(9), .RST_VAL(`ULSF_PIN_RST)) u_sync (
    .clk  (CLK_SYS),
    .rst  (RST),
    .din  ({RX_PUSH, RX_POP, RX_TAG_IN, RX_OVERRUN, RX_DATA_READY,
            TX_HOLD_EMPTY, TX_SHIFT_EMPTY}),
    .dout (s)
  );
  wire       push_lv   = s[8];
  wire       pop_lv    = s[7];
  wire [2:0] tag_in    = s[6:4];
  wire       ovr_lv    = s[3];
  wire       dr_lv     = s[2];
  wire       hold_emp  = s[1];
  wire       shift_emp = s[0];

  // rising-edge detectors; old levels reset to the idle low pin level
  reg        push_old_q;
  reg        pop_old_q;
  reg        ovr_old_q;
  wire       push_ev = push_lv & ~push_old_q;
  wire       pop_ev  = pop_lv & ~pop_old_q;
  wire       ovr_ev  = ovr_lv & ~ovr_old_q;

  // apb decode; two-cycle access phase with one wait state
  wire       acc     = PSEL & PENABLE;
  wire       wr      = acc & PWRITE;
  wire       hit_lcr = (PADDR == `ULSF_ADDR_LINE_COND);
  wire       hit_ctl = (PADDR == `ULSF_ADDR_CTRL);
  wire       hit_tag = (PADDR == `ULSF_ADDR_RXTAG);
  wire       hit_tx  = (PADDR == `ULSF_ADDR_TXSTAT);
  wire       mapped  = hit_lcr | hit_ctl | hit_tag | hit_tx;
  wire       lcr_rd  = acc & ~PWRITE & hit_lcr & ~PREADY;

  reg  [1:0]    ctrl_q;
  wire          fifo_mode = ctrl_q[`ULSF_CTRL_FIFO_MODE];
  reg  [2:0]    tag_q [0:DEPTH-1];
  reg  [DEPTH-1:0] valid_q;
  reg  [AW-1:0] wp_q;
  reg  [AW-1:0] rp_q;
  reg  [2:0]    err_q;    // sticky parity, framing, break of top char
  reg           ovr_q;
  reg           tx_idle_q;
  reg           fifo_err_q;
  wire [7:0]    lcr_val;

  // per-slot error tags, one slot per fifo entry
  // limitation: no overflow guard, a push into a full fifo reuses a slot
  wire [DEPTH-1:0] slot_err;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
      // slot number at pointer width, so the pointer compare is matched
      localparam [AW-1:0] SLOT = g;
      assign slot_err[g] = valid_q[g] & (|tag_q[g]);
      always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          tag_q[g]   <= 3'h0;
          valid_q[g] <= 1'b0;
        end else if (push_ev && wp_q == SLOT) begin
          tag_q[g]   <= tag_in;
          valid_q[g] <= 1'b1;
        end else if (pop_ev && rp_q == SLOT) begin
          valid_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // top-of-fifo tag shown in fifo mode, last char in holding mode
  wire [AW-1:0] top_idx = fifo_mode ? rp_q : (wp_q - {{(AW-1){1'b0}}, 1'b1});
  wire [2:0]    top_tag = valid_q[top_idx] ? tag_q[top_idx] : 3'h0;
  // the slot array settles one edge after the event, so the tag of the
  // new top character is taken a cycle late; in fifo mode a push behind an
  // occupied top slot leaves the flags alone, so a cleared error stays cleared
  wire          top_move_d = fifo_mode ? (pop_ev | (push_ev & ~valid_q[rp_q]))
                                       : push_ev;
  reg           top_move_q;
  wire [2:0]    new_err = top_move_q ? top_tag : 3'h0;
  // a new error beats a clearing read in the same cycle
  wire [2:0]    err_d   = (lcr_rd ? 3'h0 : err_q) | new_err;
  wire          ovr_d   = ovr_ev | (ovr_q & ~lcr_rd);
  wire          rls_any = |lcr_val[`ULSF_BIT_BREAK:`ULSF_BIT_OVERRUN];
  wire          irq_en  = ctrl_q[`ULSF_CTRL_RLS_EN];

  assign lcr_val[`ULSF_BIT_FIFO_ERR]   = fifo_mode & fifo_err_q;
  assign lcr_val[`ULSF_BIT_TX_IDLE]    = tx_idle_q;
  assign lcr_val[`ULSF_BIT_HOLD_EMPTY] = hold_emp;
  assign lcr_val[`ULSF_BIT_BREAK]      = err_q[2];
  assign lcr_val[`ULSF_BIT_FRAMING]    = err_q[1];
  assign lcr_val[`ULSF_BIT_PARITY]     = err_q[0];
  assign lcr_val[`ULSF_BIT_OVERRUN]    = ovr_q;
  assign lcr_val[`ULSF_BIT_DATA_READY] = dr_lv;

  // read mux; an unmapped address reads zero and answers with an error
  reg  [31:0]   rdata_d;
  always @* begin
    rdata_d = 32'h0;
    case (PADDR)
      `ULSF_ADDR_LINE_COND: begin
        rdata_d = {24'h0, lcr_val};
      end
      `ULSF_ADDR_CTRL: begin
        rdata_d = {30'h0, ctrl_q};
      end
      `ULSF_ADDR_RXTAG: begin
        rdata_d = {29'h0, top_tag};
      end
      `ULSF_ADDR_TXSTAT: begin
        rdata_d = {30'h0, hold_emp, shift_emp};
      end
      default: begin
        rdata_d = 32'h0;
      end
    endcase
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      push_old_q <= 1'b0;
      pop_old_q  <= 1'b0;
      ovr_old_q  <= 1'b0;
      wp_q       <= {AW{1'b0}};
      rp_q       <= {AW{1'b0}};
      top_move_q <= 1'b0;
    end else begin
      push_old_q <= push_lv;
      pop_old_q  <= pop_lv;
      ovr_old_q  <= ovr_lv;
      top_move_q <= top_move_d;
      if (push_ev) begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop_ev) begin
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // bits 6 and 7 lag their synchronised inputs by one edge
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      err_q      <= 3'h0;
      ovr_q      <= 1'b0;
      tx_idle_q  <= 1'b1;
      fifo_err_q <= 1'b0;
      RLS_IRQ    <= 1'b0;
    end else begin
      err_q      <= err_d;
      ovr_q      <= ovr_d;
      tx_idle_q  <= hold_emp & shift_emp;
      fifo_err_q <= |slot_err;
      RLS_IRQ    <= irq_en & rls_any;
    end
  end

  // control register; the status register ignores writes
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q <= 2'h0;
    end else if (wr && hit_ctl && !PREADY) begin
      ctrl_q <= PWDATA[1:0];
    end
  end

  // one wait state: ready rises the cycle after the access is taken
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      // writes to the status register are dropped
      PREADY  <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & ~mapped;
      if (acc && !PWRITE && !PREADY) begin
        PRDATA <= rdata_d;
      end
    end
  end
endmodule // ulsf_top
`default_nettype wire

// file: rtl/ulsf_defs.vh
// Purpose: constants for the line status flag block
// Assumes: 32-bit apb, one register per aligned word
// Notes:   printed offset 0x5 is not a multiple of four, so it is an index
`ifndef ULSF_DEFS_VH
`define ULSF_DEFS_VH
`define ULSF_IDX_LINE_COND   8'h05
`define ULSF_ADDR_LINE_COND  12'h014
`define ULSF_ADDR_CTRL       12'h020
`define ULSF_ADDR_RXTAG      12'h024
`define ULSF_ADDR_TXSTAT     12'h028
`define ULSF_BIT_DATA_READY  0
`define ULSF_BIT_OVERRUN     1
`define ULSF_BIT_PARITY      2
`define ULSF_BIT_FRAMING     3
`define ULSF_BIT_BREAK       4
`define ULSF_BIT_HOLD_EMPTY  5
`define ULSF_BIT_TX_IDLE     6
`define ULSF_BIT_FIFO_ERR    7
`define ULSF_CTRL_FIFO_MODE  0
`define ULSF_CTRL_RLS_EN     1
`define ULSF_LCR_RESET       8'h60
`define ULSF_FIFO_DEPTH      16
// reset level of the nine synchronised pins; the two tx empty pins idle high
`define ULSF_PIN_RST         9'h003
`endif

// file: rtl/ulsf_sync.v
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ulsf_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // ulsf_sync
`default_nettype wire

// file: test/ulsf_monitor.sv
// Purpose: port assertions for ulsf_top
// Assumes: status checks wait until pin synchronisers settle
// Notes: fifo mode is not visible here, the bench checks bit 7
`timescale 1ns/1ps
`default_nettype none
module ulsf_monitor (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_PUSH,
  input wire logic        RX_POP,
  input wire logic        RX_OVERRUN,
  input wire logic        TX_HOLD_EMPTY,
  input wire logic        TX_SHIFT_EMPTY,
  input wire logic        RLS_IRQ
);
  logic [3:0] rxq_q;
  logic [3:0] txq_q;
  logic [1:0] tx_q;
  wire        rd = PREADY & !PWRITE & (PADDR == 12'h014);
  wire  [1:0] tx = {TX_HOLD_EMPTY, TX_SHIFT_EMPTY};
  // quiet counters: pins need up to four cycles to reach the flags, five to reach the irq
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rxq_q <= 4'h0;
      txq_q <= 4'h0;
      tx_q  <= 2'h3;
    end else begin
      rxq_q <= (RX_PUSH | RX_POP | RX_OVERRUN) ? 4'h0 : rxq_q + 4'(rxq_q < 9);
      txq_q <= (tx != tx_q) ? 4'h0 : txq_q + 4'(txq_q < 9);
      tx_q  <= tx;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_take; PSEL & PENABLE & !PREADY; endsequence
  sequence s_qrd; rd & (rxq_q > 6); endsequence
  sequence s_trd; rd & (txq_q > 6); endsequence
  AST_ACK: assert property (s_take |=> PREADY)
    else $error("ready late");
  AST_ONE: assert property (PREADY |=> !PREADY) else $error("ready long");
  AST_ERR: assert property (PSLVERR |-> PREADY & (PADDR != 12'h014))
    else $error("bad slverr");
  AST_IDLE: assert property (s_trd ##0 (&tx) |-> PRDATA[6])
    else $error("tx idle low");
  AST_BUSY: assert property (s_trd ##0 !(&tx) |-> !PRDATA[6])
    else $error("tx idle high");
  AST_NOERR: assert property (s_qrd ##0 (PRDATA[4:1] == 0) |-> !RLS_IRQ)
    else $error("irq without error");
  AST_CLEAR: assert property (s_qrd |-> ##2 !RLS_IRQ)
    else $error("read kept irq");
endmodule // ulsf_monitor
bind ulsf_top ulsf_monitor mon_u (.*);
`default_nettype wire

// file: test/ulsf_host.sv
// Purpose: apb host model for the status block
// Assumes: waits on pready with no cycle count of its own
// Notes: the bench watchdog ends a hung wait
`timescale 1ns/1ps
`default_nettype none
module ulsf_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // ulsf_host
`default_nettype wire

// file: test/ulsf_top_tb_top.sv
// Purpose: self-checking bench for ulsf_top
// Assumes: pins settle within eight cycles
// Notes: data ready pin tied low
`timescale 1ns/1ps
`default_nettype none
module ulsf_top_tb_top;
  logic clk_sys = 0, rst = 1, rx_push = 0, rx_pop = 0, rx_ovr = 0;
  logic tx_hold = 1, tx_shift = 1, irq, e, psel, pen, pwr, prdy, perr;
  logic [2:0] rx_tag = 0;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r;
  logic [7:0] v;
  int n_mismatch = 0, comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  ulsf_host host_u (.clk(clk_sys), .pready(prdy), .pslverr(perr),
    .prdata(prd), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(pa),
    .pwdata(pwd));
  ulsf_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .RX_PUSH(rx_push), .RX_POP(rx_pop), .RX_TAG_IN(rx_tag),
    .RX_OVERRUN(rx_ovr), .RX_DATA_READY(1'b0), .TX_HOLD_EMPTY(tx_hold),
    .TX_SHIFT_EMPTY(tx_shift), .RLS_IRQ(irq));
  task automatic chk(input string nm, input logic [7:0] s, x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0, r, e);
    v = r[7:0];
  endtask
  // k selects push, pop or overrun; pulse held two cycles for the sync
  task automatic ev(input int k, input logic [2:0] t);
    rx_tag <= t;
    repeat (2) @(posedge clk_sys);
    {rx_ovr, rx_pop, rx_push} <= 3'(1 << k);
    repeat (2) @(posedge clk_sys);
    {rx_ovr, rx_pop, rx_push} <= 3'h0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_tx;
    for (int i = 0; i < 4; i++) begin
      {tx_hold, tx_shift} <= 2'(i);
      repeat (8) @(posedge clk_sys);
      rd(12'h014);
      chk("tx idle", {7'h0, v[6]}, {7'h0, i == 3});
    end
  endtask
  task automatic t_fifo;
    host_u.xfer(1'b1, 12'h020, 32'h3, r, e);
    ev(0, 3'h1);
    chk("irq", {7'h0, irq}, 8'h1);
    rd(12'h014);
    chk("status", v, 8'he4);
    rd(12'h014);
    chk("cleared", v, 8'he0);
    chk("irq off", {7'h0, irq}, 8'h0);
    ev(1, 3'h0);
    rd(12'h014);
    chk("fifo err", {7'h0, v[7]}, 8'h0);
    ev(0, 3'h0);
    ev(0, 3'h2);
    rd(12'h014);
    chk("any char", v, 8'he0);
    ev(1, 3'h0);
    rd(12'h014);
    chk("top framing", v, 8'he8);
    ev(1, 3'h0);
    rd(12'h014);
    chk("drained", v, 8'h60);
  endtask
  task automatic t_single;
    host_u.xfer(1'b1, 12'h020, 32'h2, r, e);
    ev(0, 3'h4);
    host_u.xfer(1'b1, 12'h014, 32'hff, r, e);
    chk("wr err", {7'h0, e}, 8'h0);
    rd(12'h014);
    chk("single", v, 8'h70);
    ev(2, 3'h0);
    rd(12'h014);
    chk("overrun", v, 8'h62);
    rd(12'h030);
    chk("slverr", {7'h0, e}, 8'h1);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h014);
    chk("reset", v, 8'h60);
    t_tx;
    t_fifo;
    t_single;
    conclude;
  end
  initial begin
    #2000000;
    n_mismatch++;
    conclude;
  end
endmodule // ulsf_top_tb_top
`default_nettype wire
